/* rtl/dfce_consts.svh */
// constants of the disk and file command engine
`ifndef DFCE_CONSTS_SVH
`define DFCE_CONSTS_SVH

// command codes seen on the host command port
`define DFCE_CMD_GET_STATUS   8'h22
`define DFCE_CMD_READ_RESULT  8'h27
`define DFCE_CMD_GET_SIZE     8'h0C
`define DFCE_CMD_CONNECT      8'h30
`define DFCE_CMD_MOUNT        8'h31
`define DFCE_CMD_OPEN         8'h32
`define DFCE_CMD_ENUM_GO      8'h33
`define DFCE_CMD_CREATE       8'h34
`define DFCE_CMD_ERASE        8'h35

// completion status bytes
`define DFCE_ST_SUCCESS       8'h14
`define DFCE_ST_DISK_READ     8'h1D
`define DFCE_ST_OPEN_DIR      8'h41
`define DFCE_ST_MISS_FILE     8'h42
`define DFCE_ST_DISCON        8'h82

// result block lengths and file length values
`define DFCE_MOUNT_LEN        8'h24
`define DFCE_RECORD_LEN       8'h20
`define DFCE_SIZE_LEN         8'h04
`define DFCE_SIZE_INVALID     32'h0FFFFFFF
`define DFCE_SIZE_NEW         32'h00000001
`define DFCE_SIZE_ZERO        32'h00000000

// defaults stamped on a new file: 2004-01-01, 0:0:0
`define DFCE_NEW_DATE         16'h3021
`define DFCE_NEW_TIME         16'h0000

// widths and reset values
`define DFCE_PTR_ONE          6'h01
`define DFCE_PTR_ZERO         6'h00
`define DFCE_BYTE_ZERO        8'h00

`endif

/* rtl/dfce_pkg.sv */
// types of the disk and file command engine
package dfce_pkg;

	// engine states, one-hot
	typedef enum logic [1:0] {
		DFCE_IDLE = 2'b01,
		DFCE_WAIT = 2'b10
	} dfce_state_type;

	// operations handed to the media back end
	typedef enum logic [3:0] {
		DFCE_OP_NONE      = 4'h0,
		DFCE_OP_CONNECT   = 4'h1,
		DFCE_OP_MOUNT     = 4'h2,
		DFCE_OP_FS_INIT   = 4'h3,
		DFCE_OP_OPEN      = 4'h4,
		DFCE_OP_OPEN_ROOT = 4'h5,
		DFCE_OP_ENUM_NEXT = 4'h6,
		DFCE_OP_CREATE    = 4'h7,
		DFCE_OP_DEL_OPEN  = 4'h8,
		DFCE_OP_ERASE     = 4'h9
	} dfce_op_type;

endpackage

/* rtl/dfce_engine.sv */
// command engine for media and file commands
// What this block does
// - presence query only in usb mode, interrupts
// - successful mount leaves 36-byte result block
// - mount accepted any time, reports readiness
// - directory open gives 41h, length 0fffffffh
// - file open gives success, valid length
// - open of missing name gives 42h
// - empty name initialises file system only
// - single slash opens root; host closes it
// - each enumerated match: disk-read, record readable
// - continue resumes; no match ends with 42h
// - record carries attribute and name fields
// - create replaces existing file, no wildcards
// - new file dated 2004-01-01, length one
// - erase deletes open file, else named
// - directory-opened status byte is 41h
// - missing-file status byte is 42h
`timescale 1ns/10ps
`default_nettype none
`include "dfce_consts.svh"

module dfce_engine
	import dfce_pkg::*;
#(
	parameter int BUF_DEPTH = 64
) (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        reset_in,
	// host command port
	input  wire logic        cmd_valid_in,
	input  wire logic [7:0]  cmd_code_in,
	input  wire logic        data_rd_in,
	output logic             cmd_ready_out,
	output logic [7:0]       data_out,
	output logic             int_n_out,
	// mode and name facts from the name block
	input  wire logic        usb_host_mode_in,
	input  wire logic        name_empty_in,
	input  wire logic        name_root_in,
	input  wire logic        name_wild_in,
	// media back end request
	output logic             be_req_out,
	output dfce_op_type      be_op_out,
	output logic [15:0]      new_date_out,
	output logic [15:0]      new_time_out,
	output logic [31:0]      new_size_out,
	// media back end answer
	input  wire logic        be_done_in,
	input  wire logic        be_ok_in,
	input  wire logic        be_miss_in,
	input  wire logic        be_dir_in,
	input  wire logic [7:0]  be_err_in,
	input  wire logic [31:0] be_size_in,
	// result block fill from the back end
	input  wire logic        res_wr_in,
	input  wire logic [5:0]  res_addr_in,
	input  wire logic [7:0]  res_byte_in
);

	// state registers
	dfce_state_type state;
	dfce_op_type    op;
	logic [7:0]     status;
	logic           pending;
	logic [7:0]     res_len;
	logic [31:0]    file_size;
	logic           file_open;
	logic           fs_ready;
	logic           enum_on;
	logic           size_mode;
	logic [5:0]     rd_ptr;
	logic           reading;
	logic [7:0]     dout;
	logic [7:0]     res_buf [0:BUF_DEPTH-1];

	// next values
	dfce_state_type next_state;
	dfce_op_type    next_op;
	logic [7:0]     next_status;
	logic           next_pending;
	logic [7:0]     next_res_len;
	logic [31:0]    next_file_size;
	logic           next_file_open;
	logic           next_fs_ready;
	logic           next_enum_on;
	logic           next_size_mode;
	logic [5:0]     next_rd_ptr;
	logic           next_reading;
	logic [7:0]     next_dout;
	logic           cmd_take;
	logic [7:0]     rd_byte;

	assign cmd_take = cmd_valid_in && (state == DFCE_IDLE);

	// byte served on a data read: file length in size mode, else block
	always_comb begin
		if (size_mode) begin
			rd_byte = file_size[{rd_ptr[1:0], 3'b000} +: 8]; // little-endian length
		end else begin
			rd_byte = res_buf[rd_ptr];
		end
	end

	// command decode, back end completion and result reads
	always_comb begin
		next_state     = state;
		next_op        = op;
		next_status    = status;
		next_pending   = pending;
		next_res_len   = res_len;
		next_file_size = file_size;
		next_file_open = file_open;
		next_fs_ready  = fs_ready;
		next_enum_on   = enum_on;
		next_size_mode = size_mode;
		next_rd_ptr    = rd_ptr;
		next_reading   = reading;
		next_dout      = dout;
		case (state)
			DFCE_IDLE: begin
				if (data_rd_in && reading) begin
					if ({2'b00, rd_ptr} < res_len) begin
						next_dout   = rd_byte;
						next_rd_ptr = rd_ptr + `DFCE_PTR_ONE;
					end else begin
						next_reading = 1'b0;
					end
				end
				if (cmd_take) begin
					next_reading = 1'b0;
					case (cmd_code_in)
						`DFCE_CMD_GET_STATUS: begin
							next_dout    = status;
							next_pending = 1'b0;
						end
						`DFCE_CMD_READ_RESULT: begin
							next_dout    = res_len;
							next_rd_ptr  = `DFCE_PTR_ZERO;
							next_reading = 1'b1;
						end
						`DFCE_CMD_GET_SIZE: begin
							// directory reports invalid length here too
							next_size_mode = 1'b1;
							next_res_len   = `DFCE_SIZE_LEN;
							next_dout      = `DFCE_SIZE_LEN;
							next_rd_ptr    = `DFCE_PTR_ZERO;
							next_reading   = 1'b1;
						end
						`DFCE_CMD_CONNECT: begin
							if (usb_host_mode_in) begin
								next_op    = DFCE_OP_CONNECT;
								next_state = DFCE_WAIT;
							end else begin
								next_status  = `DFCE_ST_DISCON; // sd media
								next_pending = 1'b1;
							end
						end
						`DFCE_CMD_MOUNT: begin
							next_op    = DFCE_OP_MOUNT; // any time
							next_state = DFCE_WAIT;
						end
						`DFCE_CMD_OPEN: begin
							next_enum_on = 1'b0;
							if (name_empty_in && fs_ready) begin
								next_status  = `DFCE_ST_SUCCESS;
								next_pending = 1'b1;
							end else begin
								if (name_empty_in) begin
									next_op = DFCE_OP_FS_INIT;
								end else if (name_root_in) begin
									next_op = DFCE_OP_OPEN_ROOT;
								end else if (name_wild_in) begin
									next_op      = DFCE_OP_ENUM_NEXT;
									next_enum_on = 1'b1;
								end else begin
									next_op = DFCE_OP_OPEN;
								end
								next_state = DFCE_WAIT;
							end
						end
						`DFCE_CMD_ENUM_GO: begin
							if (enum_on) begin
								next_op    = DFCE_OP_ENUM_NEXT;
								next_state = DFCE_WAIT;
							end else begin
								next_status  = `DFCE_ST_MISS_FILE;
								next_pending = 1'b1;
							end
						end
						`DFCE_CMD_CREATE, `DFCE_CMD_ERASE: begin
							next_enum_on = 1'b0;
							if (name_wild_in && !(file_open && cmd_code_in == `DFCE_CMD_ERASE)) begin
								next_status  = `DFCE_ST_MISS_FILE; // no wildcard
								next_pending = 1'b1;
							end else begin
								if (cmd_code_in == `DFCE_CMD_CREATE) begin
									next_op = DFCE_OP_CREATE; // delete then create
								end else if (file_open) begin
									next_op = DFCE_OP_DEL_OPEN;
								end else begin
									next_op = DFCE_OP_ERASE; // open then delete
								end
								next_state = DFCE_WAIT;
							end
						end
						default: begin
							next_status  = status;
						end
					endcase
					if (cmd_code_in != `DFCE_CMD_GET_SIZE && cmd_code_in != `DFCE_CMD_GET_STATUS &&
						cmd_code_in != `DFCE_CMD_READ_RESULT) begin
						next_size_mode = 1'b0;
					end
				end
			end
			DFCE_WAIT: begin
				if (be_done_in) begin
					next_state   = DFCE_IDLE;
					next_pending = 1'b1; // every back end command ends with an interrupt
					next_res_len = `DFCE_BYTE_ZERO;
					if (be_ok_in) begin
						next_status = `DFCE_ST_SUCCESS;
					end else if (be_miss_in) begin
						next_status = `DFCE_ST_MISS_FILE;
					end else begin
						next_status = be_err_in;
					end
					case (op)
						DFCE_OP_MOUNT: begin
							next_fs_ready = be_ok_in;
							if (be_ok_in) begin
								next_res_len = `DFCE_MOUNT_LEN;
							end
						end
						DFCE_OP_FS_INIT: begin
							next_fs_ready = be_ok_in;
						end
						DFCE_OP_OPEN, DFCE_OP_OPEN_ROOT: begin
							if (be_ok_in && (be_dir_in || op == DFCE_OP_OPEN_ROOT)) begin
								next_status    = `DFCE_ST_OPEN_DIR;
								next_file_size = `DFCE_SIZE_INVALID;
								next_file_open = 1'b1;
							end else if (be_ok_in) begin
								next_file_size = be_size_in;
								next_file_open = 1'b1;
							end
						end
						DFCE_OP_ENUM_NEXT: begin
							if (be_ok_in) begin
								next_status  = `DFCE_ST_DISK_READ;
								next_res_len = `DFCE_RECORD_LEN; // record incl. name and attr
							end else begin
								next_enum_on = 1'b0; // end of enumeration
							end
						end
						DFCE_OP_CREATE: begin
							if (be_ok_in) begin
								next_file_size = `DFCE_SIZE_NEW;
								next_file_open = 1'b1;
							end
						end
						DFCE_OP_DEL_OPEN, DFCE_OP_ERASE: begin
							if (be_ok_in) begin
								next_file_open = 1'b0;
								next_file_size = `DFCE_SIZE_ZERO;
							end
						end
						default: begin
							next_op = DFCE_OP_NONE;
						end
					endcase
				end
			end
			default: begin
				next_state = DFCE_IDLE;
			end
		endcase
	end

	// control registers
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			state     <= DFCE_IDLE;
			op        <= DFCE_OP_NONE;
			status    <= `DFCE_BYTE_ZERO;
			pending   <= 1'b0;
			res_len   <= `DFCE_BYTE_ZERO;
			file_size <= `DFCE_SIZE_ZERO;
			file_open <= 1'b0;
			fs_ready  <= 1'b0;
			enum_on   <= 1'b0;
			size_mode <= 1'b0;
			rd_ptr    <= `DFCE_PTR_ZERO;
			reading   <= 1'b0;
			dout      <= `DFCE_BYTE_ZERO;
		end else begin
			state     <= next_state;
			op        <= next_op;
			status    <= next_status;
			pending   <= next_pending;
			res_len   <= next_res_len;
			file_size <= next_file_size;
			file_open <= next_file_open;
			fs_ready  <= next_fs_ready;
			enum_on   <= next_enum_on;
			size_mode <= next_size_mode;
			rd_ptr    <= next_rd_ptr;
			reading   <= next_reading;
			dout      <= next_dout;
		end
	end

	// result block store, filled by the back end
	always_ff @(posedge mclk_in) begin
		if (res_wr_in) begin
			res_buf[res_addr_in] <= res_byte_in;
		end
	end

	// outputs
	assign cmd_ready_out = (state == DFCE_IDLE);
	assign data_out      = dout;
	assign int_n_out     = !pending;
	assign be_req_out    = (state == DFCE_WAIT);
	assign be_op_out     = op;
	assign new_date_out  = `DFCE_NEW_DATE;
	assign new_time_out  = `DFCE_NEW_TIME;
	assign new_size_out  = `DFCE_SIZE_NEW;

endmodule
`default_nettype wire

/* testbench/dfce_monitor.sv */
// port assertions for the command engine
`timescale 1ns/10ps
`default_nettype none
`include "dfce_consts.svh"
module dfce_monitor
	import dfce_pkg::*;
(
	// clock and reset
	input wire logic        mclk_in,
	input wire logic        reset_in,
	// command side
	input wire logic        cmd_valid_in,
	input wire logic [7:0]  cmd_code_in,
	input wire logic        cmd_ready_out,
	input wire logic        int_n_out,
	input wire logic        usb_host_mode_in,
	input wire logic        name_wild_in,
	// back end side
	input wire logic        be_req_out,
	input wire dfce_op_type be_op_out,
	input wire logic [15:0] new_date_out,
	input wire logic [15:0] new_time_out,
	input wire logic [31:0] new_size_out,
	input wire logic        be_done_in
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	// a command taken, and a back end answer
	sequence s_take(c);
		cmd_valid_in && cmd_ready_out && cmd_code_in == c;
	endsequence
	sequence s_end;
		be_req_out && be_done_in;
	endsequence
	property p_idle;
		cmd_ready_out == !be_req_out;
	endproperty
	property p_mount;
		s_take(`DFCE_CMD_MOUNT) |=> be_req_out && be_op_out == DFCE_OP_MOUNT;
	endproperty
	property p_make;
		s_take(`DFCE_CMD_CREATE) ##0 !name_wild_in |=> be_req_out && be_op_out == DFCE_OP_CREATE;
	endproperty
	property p_nowild;
		s_take(`DFCE_CMD_CREATE) ##0 name_wild_in |=> !be_req_out && !int_n_out;
	endproperty
	property p_hold;
		be_req_out && !be_done_in |=> be_req_out && $stable(be_op_out);
	endproperty
	property p_end;
		s_end |=> !int_n_out && !be_req_out;
	endproperty
	property p_clr;
		s_take(`DFCE_CMD_GET_STATUS) |=> int_n_out;
	endproperty
	property p_sd;
		s_take(`DFCE_CMD_CONNECT) ##0 !usb_host_mode_in |=> !int_n_out && !be_req_out;
	endproperty
	property p_new;
		new_date_out == `DFCE_NEW_DATE && new_time_out == `DFCE_NEW_TIME
			&& new_size_out == `DFCE_SIZE_NEW;
	endproperty
	a_idle: assert property (p_idle) else $error("ready wrong");
	a_mount: assert property (p_mount) else $error("mount not passed on");
	a_make: assert property (p_make) else $error("create not passed on");
	a_nowild: assert property (p_nowild) else $error("wild create run");
	a_hold: assert property (p_hold) else $error("request dropped");
	a_end: assert property (p_end) else $error("no completion");
	a_clr: assert property (p_clr) else $error("interrupt kept");
	a_sd: assert property (p_sd) else $error("sd query wrong");
	a_new: assert property (p_new) else $error("new file stamp");
endmodule
bind dfce_engine dfce_monitor mon (.mclk_in, .reset_in, .cmd_valid_in, .cmd_code_in,
	.cmd_ready_out, .int_n_out, .usb_host_mode_in, .name_wild_in, .be_req_out,
	.be_op_out, .new_date_out, .new_time_out, .new_size_out, .be_done_in);
`default_nettype wire

/* testbench/dfce_media_model.sv */
// media back end model with set answer and latency
`timescale 1ns/10ps
`default_nettype none
module dfce_media_model (
	// clock, reset, request
	input wire logic        mclk_in,
	input wire logic        reset_in,
	input wire logic        be_req_in,
	// answer set by the bench
	input wire logic [2:0]  res_in,
	input wire logic [7:0]  err_in,
	input wire logic [31:0] size_in,
	input wire logic [3:0]  lat_in,
	// answer
	output logic            done_out,
	output logic [2:0]      res_out,
	output logic [7:0]      err_out,
	output logic [31:0]     size_out
);
	logic [3:0] cnt;
	// wait count per request
	always_ff @(posedge mclk_in) begin
		if (reset_in || !be_req_in || done_out)
			cnt <= 4'h0;
		else
			cnt <= cnt + 4'h1;
	end
	// answers only valid with done
	assign done_out = be_req_in && cnt == lat_in;
	assign res_out = done_out ? res_in : ~res_in;
	assign err_out = done_out ? err_in : ~err_in;
	assign size_out = done_out ? size_in : ~size_in;
endmodule
`default_nettype wire

/* testbench/disk_file_command_engine_bench.sv */
// self-checking bench for the command engine
`timescale 1ns/10ps
`default_nettype none
`include "dfce_consts.svh"
module disk_file_command_engine_bench
	import dfce_pkg::*;
;
	logic mclk_in = 0, reset_in = 1, cmd_valid_in = 0, data_rd_in = 0, res_wr_in = 0;
	logic usb_host_mode_in = 1, name_empty_in = 0, name_root_in = 0, name_wild_in = 0;
	logic [7:0] cmd_code_in = 0, res_byte_in = 0, m_err = 8'h92;
	logic [5:0] res_addr_in = 0;
	logic [2:0] m_res = 0;
	logic [3:0] m_lat = 0;
	logic [31:0] m_size = 0, seed = 32'h6d327345;
	logic [7:0] blk [36];
	wire logic cmd_ready_out, int_n_out, be_req_out, be_done_in, be_ok_in, be_miss_in, be_dir_in;
	wire logic [7:0] data_out, be_err_in;
	wire logic [15:0] new_date_out, new_time_out;
	wire logic [31:0] new_size_out, be_size_in;
	wire dfce_op_type be_op_out;
	int err_count = 0, tests_run = 0;
	always #20 mclk_in = ~mclk_in;
	dfce_engine dut (.mclk_in, .reset_in, .cmd_valid_in, .cmd_code_in, .data_rd_in,
		.cmd_ready_out, .data_out, .int_n_out, .usb_host_mode_in, .name_empty_in,
		.name_root_in, .name_wild_in, .be_req_out, .be_op_out, .new_date_out,
		.new_time_out, .new_size_out, .be_done_in, .be_ok_in, .be_miss_in, .be_dir_in,
		.be_err_in, .be_size_in, .res_wr_in, .res_addr_in, .res_byte_in);
	dfce_media_model media (.mclk_in, .reset_in, .be_req_in(be_req_out), .res_in(m_res),
		.err_in(m_err), .size_in(m_size), .lat_in(m_lat), .done_out(be_done_in),
		.res_out({be_ok_in, be_miss_in, be_dir_in}), .err_out(be_err_in),
		.size_out(be_size_in));
	task automatic give_verdict;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one-cycle command strobe
	task automatic cmd(input logic [7:0] c);
		@(negedge mclk_in);
		cmd_valid_in = 1;
		cmd_code_in = c;
		@(negedge mclk_in);
		cmd_valid_in = 0;
	endtask
	task automatic rd(input logic [7:0] exp);
		@(negedge mclk_in);
		data_rd_in = 1;
		@(negedge mclk_in);
		data_rd_in = 0;
		chk(32'(data_out), 32'(exp));
	endtask
	// command, wait for interrupt, then status
	task automatic run(input logic [7:0] c, input dfce_op_type op, input logic [7:0] st);
		int n;
		m_lat = 4'($unsigned($random(seed)) % 8);
		cmd(c);
		if (op != DFCE_OP_NONE)
			chk({be_req_out, 27'h0, be_op_out}, {1'b1, 27'h0, op});
		for (n = 0; n < 50 && int_n_out !== 1'b0; n++)
			@(negedge mclk_in);
		if (n == 50) begin
			chk(0, 1);
			give_verdict;
		end
		cmd(`DFCE_CMD_GET_STATUS);
		chk(32'(data_out), 32'(st));
	endtask
	task automatic blk_chk(input logic [7:0] len, input int n);
		cmd(`DFCE_CMD_READ_RESULT);
		chk(32'(data_out), 32'(len));
		for (int i = 0; i < n; i++)
			rd(blk[i]);
	endtask
	task automatic sz(input logic [31:0] v);
		cmd(`DFCE_CMD_GET_SIZE);
		chk(32'(data_out), 32'(`DFCE_SIZE_LEN));
		for (int k = 0; k < 4; k++)
			rd(v[k*8 +: 8]);
	endtask
	// main sequence
	initial begin
		repeat (5) @(negedge mclk_in);
		reset_in = 0;
		@(negedge mclk_in);
		chk(32'({int_n_out, cmd_ready_out, be_req_out, data_out}), 32'h00000600);
		m_res = 3'b100;
		run(`DFCE_CMD_CONNECT, DFCE_OP_CONNECT, `DFCE_ST_SUCCESS);
		usb_host_mode_in = 0;
		run(`DFCE_CMD_CONNECT, DFCE_OP_NONE, `DFCE_ST_DISCON);
		usb_host_mode_in = 1;
		$display("presence done");
		for (int i = 0; i < 36; i++) begin
			@(negedge mclk_in);
			blk[i] = 8'($random(seed));
			{res_wr_in, res_addr_in, res_byte_in} = {1'b1, 6'(i), blk[i]};
		end
		@(negedge mclk_in);
		res_wr_in = 0;
		m_res = 3'b000;
		run(`DFCE_CMD_MOUNT, DFCE_OP_MOUNT, m_err);
		{name_empty_in, m_res} = 4'b1100;
		run(`DFCE_CMD_OPEN, DFCE_OP_FS_INIT, `DFCE_ST_SUCCESS);
		run(`DFCE_CMD_MOUNT, DFCE_OP_MOUNT, `DFCE_ST_SUCCESS);
		blk_chk(`DFCE_MOUNT_LEN, 36);
		run(`DFCE_CMD_OPEN, DFCE_OP_NONE, `DFCE_ST_SUCCESS);
		{name_empty_in, name_root_in} = 2'b01;
		m_res = 3'b101;
		run(`DFCE_CMD_OPEN, DFCE_OP_OPEN_ROOT, `DFCE_ST_OPEN_DIR);
		name_root_in = 0;
		run(`DFCE_CMD_OPEN, DFCE_OP_OPEN, `DFCE_ST_OPEN_DIR);
		sz(`DFCE_SIZE_INVALID);
		$display("mount and open done");
		m_res = 3'b100;
		repeat (3) begin
			m_size = $random(seed);
			run(`DFCE_CMD_OPEN, DFCE_OP_OPEN, `DFCE_ST_SUCCESS);
			sz(m_size);
		end
		run(`DFCE_CMD_ERASE, DFCE_OP_DEL_OPEN, `DFCE_ST_SUCCESS);
		m_res = 3'b010;
		run(`DFCE_CMD_OPEN, DFCE_OP_OPEN, `DFCE_ST_MISS_FILE);
		name_wild_in = 1;
		run(`DFCE_CMD_ERASE, DFCE_OP_NONE, `DFCE_ST_MISS_FILE);
		run(`DFCE_CMD_CREATE, DFCE_OP_NONE, `DFCE_ST_MISS_FILE);
		m_res = 3'b100;
		run(`DFCE_CMD_OPEN, DFCE_OP_ENUM_NEXT, `DFCE_ST_DISK_READ);
		blk_chk(`DFCE_RECORD_LEN, 12);
		run(`DFCE_CMD_ENUM_GO, DFCE_OP_ENUM_NEXT, `DFCE_ST_DISK_READ);
		m_res = 3'b010;
		run(`DFCE_CMD_ENUM_GO, DFCE_OP_ENUM_NEXT, `DFCE_ST_MISS_FILE);
		run(`DFCE_CMD_ENUM_GO, DFCE_OP_NONE, `DFCE_ST_MISS_FILE);
		$display("enumerate done");
		{name_wild_in, m_res} = 4'b0100;
		run(`DFCE_CMD_ERASE, DFCE_OP_ERASE, `DFCE_ST_SUCCESS);
		run(`DFCE_CMD_CREATE, DFCE_OP_CREATE, `DFCE_ST_SUCCESS);
		$display("create and erase done");
		give_verdict;
	end
endmodule
`default_nettype wire
